// [src/synth_cmd_tone.sv]
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module synth_cmd_tone
	import synth_cmd_pkg::*;
#(
	parameter int         BAUD_DIV  = 26041,  // cycles per serial bit
	parameter int         TICK_DIV  = 2500,   // cycles per tone tick
	parameter int         BUF_FR    = BUF_BYTES / FRAME_BYTES,
	parameter logic [7:0] ID_BYTE   = 8'h5a,  // arbitrary value
	parameter logic [7:0] REV_MAJOR = 8'h01,  // arbitrary value
	parameter logic [7:0] REV_MINOR = 8'h00   // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             serial_tx_pin,
	output logic             talk_status,
	output logic      [7:0]  analog_out_pins,
	output logic             digital_audio_pin,
	output logic             nv_we,
	output logic             nv_dict_sel,
	output logic      [13:0] nv_addr,
	output logic      [7:0]  nv_wdata,
	output logic             nv_erase_dict,
	output logic             nv_commit,
	output logic      [7:0]  nv_raddr,
	input  wire logic [7:0]  nv_rdata,
	input  wire logic [7:0]  nv_greet_len
);
	localparam int AW = $clog2(BUF_FR);

	// module state, all but the frame buffer
	typedef struct packed {
		parse_t        ps;        // byte parser state
		logic          nd;        // digits seen in command
		logic [7:0]    num;       // command argument
		logic [1:0]    pos;       // byte position in frame
		logic [23:0]   fb;        // first three frame bytes
		logic          quit_pend; // quit seen, draining
		logic          playing;
		logic          talk;
		logic [1:0]    mode;
		logic [7:0]    proto;
		logic [7:0]    aud_ctrl;
		logic          dict_loaded;
		logic [14:0]   dict_cnt;
		logic [7:0]    greet_cnt;
		logic [AW:0]   wptr;
		logic [AW:0]   rptr;
		logic [7:0]    amp;
		logic [15:0]   tempo;
		logic [23:0]   dur;
		logic [23:0]   kv;        // three frequency constants
		logic [23:0]   vc;        // three voice counters
		logic [2:0]    vout;
		logic [15:0]   tick;
		logic          tx_on;
		logic          tx_set;    // settings reply, else chip id
		logic [4:0]    tx_idx;
		logic [8:0]    tx_sh;
		logic [3:0]    tx_bits;
		logic [15:0]   tx_div;
		logic          txd;
		logic          init_done;
		logic          rp_on;
		logic          rp_pend;
		logic [7:0]    rp_len;
		logic [7:0]    rp_addr;
		logic          nv_we;
		logic          nv_dict;
		logic [13:0]   nv_addr;
		logic [7:0]    nv_wdata;
		logic          nv_erase;
		logic          nv_commit;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
		logic [7:0]    aout;
	} st_t;

	st_t         st_reg;              // registered state
	st_t         st_next;             // next state
	logic [31:0] fbuf [0:BUF_FR-1];   // tone frame buffer
	logic        buf_we;              // push a frame
	logic [31:0] buf_wd;              // frame to push
	logic [AW:0] count;               // frames buffered
	logic        full;
	logic        gate;                // parser may take a byte
	logic        apb_acc;
	logic        apb_done;
	logic        src_v;               // byte presented to parser
	logic [7:0]  src_b;

	assign count    = st_reg.wptr - st_reg.rptr;
	assign full     = (count == (AW+1)'(BUF_FR));
	// stalls keep the host waiting in the access phase, not dropping
	assign gate     = !st_reg.quit_pend && !st_reg.tx_on &&
	                  !(st_reg.ps == P_TONE && full);
	assign apb_acc  = psel && penable;
	assign apb_done = apb_acc && st_reg.pready;
	// greeting replay bytes enter the parser like host bytes, but W and L commands are ignored while replay runs
	assign src_v = st_reg.rp_on ? (st_reg.rp_pend && gate) :
	               (apb_done && pwrite && paddr == OFS_DATA);
	assign src_b = st_reg.rp_on ? nv_rdata : pwdata[7:0];

	// reply byte for a query
	function automatic logic [7:0] tx_byte(input st_t s);
		logic [7:0] b;
		b = 8'h00;
		if (!s.tx_set) begin
			if (s.tx_idx == 5'd6)
				b = REV_MINOR;
			else if (s.tx_idx == 5'd7)
				b = REV_MAJOR;
			else
				b = ID_BYTE;
		end else begin
			unique case (s.tx_idx)
				5'd0:    b = {6'h00, s.mode};
				5'd8:    b = {7'h00, s.dict_loaded};
				5'd14:   b = s.proto;
				5'd15:   b = s.aud_ctrl;
				default: b = SET_DFLT[s.tx_idx];
			endcase
		end
		return b;
	endfunction

	// next-state logic
	always_comb begin
		logic [11:0] nn;
		logic [31:0] fr;
		logic [9:0]  prod;
		logic [1:0]  vsum;
		logic        ctl_fr;  // play or quit frame taken now
		nn      = 12'h000;
		ctl_fr  = 1'b0;
		fr      = fbuf[st_reg.rptr[AW-1:0]];
		prod    = 10'h000;
		vsum    = 2'h0;
		st_next = st_reg;
		buf_we  = 1'b0;
		buf_wd  = {st_reg.fb, src_b};
		// one-cycle pulses
		st_next.nv_we     = 1'b0;
		st_next.nv_erase  = 1'b0;
		st_next.nv_commit = 1'b0;

		// catch stored greeting length after reset release
		if (!st_reg.init_done) begin
			st_next.init_done = 1'b1;
			st_next.rp_len    = nv_greet_len;
			st_next.rp_on     = (nv_greet_len != 8'h00);
		end else if (st_reg.rp_on) begin
			if (!st_reg.rp_pend) begin
				st_next.rp_pend = 1'b1;
			end else if (gate) begin
				st_next.rp_pend = 1'b0;
				st_next.rp_addr = st_reg.rp_addr + 8'h01;
				if (st_reg.rp_addr + 8'h01 == st_reg.rp_len)
					st_next.rp_on = 1'b0;
			end
		end

		// byte parser
		if (src_v) begin
			unique case (st_reg.ps)
				P_TEXT: begin
					if (src_b == CH_CTRLA) begin
						st_next.ps  = P_CMD;
						st_next.nd  = 1'b0;
						st_next.num = 8'h00;
					end
				end
				P_CMD: begin
					st_next.ps = P_TEXT;
					if (src_b >= CH_0 && src_b <= CH_9) begin
						nn = 12'(st_reg.num) * 12'd10 +
						     12'(src_b - CH_0);
						st_next.num = (nn > 12'd255) ? 8'hff : nn[7:0];
						st_next.nd  = 1'b1;
						st_next.ps  = P_CMD;
					end else if (src_b == CH_W && st_reg.nd &&
					             st_reg.num == NUM_GREET &&
					             !st_reg.rp_on) begin
						st_next.nv_erase    = 1'b1;
						st_next.dict_loaded = 1'b0;
						st_next.greet_cnt   = 8'h00;
						st_next.ps          = P_GREET;
					end else if (src_b == CH_L && !st_reg.nd &&
					             !st_reg.rp_on) begin
						st_next.nv_erase    = 1'b1;
						st_next.dict_loaded = 1'b0;
						st_next.dict_cnt    = 15'h0000;
						st_next.ps          = P_DICT;
					end else if (src_b == CH_Q && st_reg.nd &&
					             (st_reg.num == NUM_CHIP ||
					              st_reg.num == NUM_SET)) begin
						st_next.tx_on  = 1'b1;
						st_next.tx_set = (st_reg.num == NUM_SET);
						st_next.tx_idx = 5'h00;
					end else if (src_b == CH_J && !st_reg.nd) begin
						st_next.ps  = P_TONE;
						st_next.pos = 2'h0;
					end else if (src_b == CH_G && st_reg.nd) begin
						st_next.proto = st_reg.num;
					end else if (src_b == CH_N && st_reg.nd) begin
						st_next.aud_ctrl = st_reg.num;
					end else if (src_b == CH_C) begin
						st_next.mode = MODE_CHAR;
					end else if (src_b == CH_D) begin
						st_next.mode = MODE_PHON;
					end else if (src_b == CH_T) begin
						st_next.mode = MODE_TEXT;
					end
				end
				P_GREET: begin
					if (src_b == 8'h00) begin
						st_next.nv_commit = 1'b1;
						st_next.nv_addr   = {6'h00, st_reg.greet_cnt};
						st_next.ps        = P_TEXT;
					end else if (st_reg.greet_cnt < 8'(GREET_MAX)) begin
						// bytes past the limit are dropped
						st_next.nv_we     = 1'b1;
						st_next.nv_dict   = 1'b0;
						st_next.nv_addr   = {6'h00, st_reg.greet_cnt};
						st_next.nv_wdata  = src_b;
						st_next.greet_cnt = st_reg.greet_cnt + 8'h01;
					end
				end
				P_DICT: begin
					st_next.nv_we    = 1'b1;
					st_next.nv_dict  = 1'b1;
					st_next.nv_addr  = st_reg.dict_cnt[13:0];
					st_next.nv_wdata = src_b;
					st_next.dict_cnt = st_reg.dict_cnt + 15'h0001;
					if (st_reg.dict_cnt == 15'(DICT_MAX - 1)) begin
						st_next.ps          = P_TEXT;
						st_next.dict_loaded = 1'b1;
					end
				end
				P_TONE: begin
					st_next.pos = st_reg.pos + 2'h1;
					if (st_reg.pos != 2'h3) begin
						st_next.fb = {st_reg.fb[15:0], src_b};
					end else if (buf_wd == 32'h00000101) begin
						st_next.playing = 1'b1;  // play frame
						ctl_fr          = 1'b1;
						st_next.talk    = 1'b1;
					end else if (buf_wd == 32'h00000000) begin
						st_next.quit_pend = 1'b1;
						ctl_fr            = 1'b1;
						st_next.playing   = 1'b1;
						st_next.talk      = 1'b1;
						st_next.ps        = P_TEXT;
					end else begin
						// init and voice queue in order
						buf_we       = 1'b1;
						st_next.wptr = st_reg.wptr + (AW+1)'(1);
					end
				end
				default: st_next.ps = P_TEXT;
			endcase
		end

		// a full buffer starts play unasked
		if (full) begin
			st_next.playing = 1'b1;
			st_next.talk    = 1'b1;
		end

		// tone engine, idle until a play start
		st_next.tick = (st_reg.tick == 16'h0000) ?
		               16'(TICK_DIV - 1) : st_reg.tick - 16'h0001;
		if (st_reg.playing) begin
			if (st_reg.dur == 24'h000000) begin
				if (count != '0) begin
					st_next.rptr = st_reg.rptr + (AW+1)'(1);
					if (fr[31:24] == 8'h00) begin
						st_next.amp   = fr[23:16];
						st_next.tempo = {fr[7:0], fr[15:8]};
					end else begin
						st_next.kv  = fr[23:0];
						st_next.vc  = 24'h000000;
						st_next.dur = 24'(fr[31:24]) *
						              24'(st_reg.tempo);
					end
				end else if (!ctl_fr && !buf_we) begin
					// set wins: a frame taken now keeps play alive
					st_next.playing   = 1'b0;  // drained
					st_next.talk      = 1'b0;
					st_next.quit_pend = 1'b0;
					st_next.kv        = 24'h000000;
					st_next.vout      = 3'h0;
				end
			end else if (st_reg.tick == 16'h0000) begin
				st_next.dur = st_reg.dur - 24'h000001;
				for (int i = 0; i < 3; i++) begin
					if (st_reg.kv[i*8 +: 8] == 8'h00) begin
						st_next.vout[i] = 1'b0;  // silenced
					end else if (st_reg.vc[i*8 +: 8] == 8'h00) begin
						st_next.vout[i]     = !st_reg.vout[i];
						st_next.vc[i*8 +: 8] = st_reg.kv[i*8 +: 8] - 8'h01;
					end else begin
						st_next.vc[i*8 +: 8] = st_reg.vc[i*8 +: 8] - 8'h01;
					end
				end
			end
		end
		// mix voices, scale by amplitude; analog only
		vsum = 2'(st_reg.vout[0]) + 2'(st_reg.vout[1]) +
		       2'(st_reg.vout[2]);
		prod = 10'(vsum) * 10'(st_reg.amp);
		st_next.aout = st_reg.playing ? prod[9:2] : 8'h00;

		// serial transmitter, 8N1
		if (st_reg.tx_bits == 4'h0 && st_reg.tx_div == 16'h0000) begin
			if (st_reg.tx_on) begin
				if (st_reg.tx_idx == (st_reg.tx_set ?
				    5'(SET_BYTES) : 5'(CHIP_BYTES))) begin
					st_next.tx_on = 1'b0;
				end else begin
					st_next.tx_sh   = {1'b1, tx_byte(st_reg)};
					st_next.txd     = 1'b0;
					st_next.tx_bits = 4'h9;
					st_next.tx_div  = 16'(BAUD_DIV - 1);
					st_next.tx_idx  = st_reg.tx_idx + 5'h01;
				end
			end
		end else if (st_reg.tx_div == 16'h0000) begin
			st_next.txd     = st_reg.tx_sh[0];
			st_next.tx_sh   = {1'b1, st_reg.tx_sh[8:1]};
			st_next.tx_bits = st_reg.tx_bits - 4'h1;
			st_next.tx_div  = 16'(BAUD_DIV - 1);
		end else begin
			st_next.tx_div = st_reg.tx_div - 16'h0001;
		end

		// apb slave: one wait state, data writes wait for the parser
		st_next.pready  = apb_acc && !st_reg.pready &&
		                  !(pwrite && paddr == OFS_DATA &&
		                    (!gate || st_reg.rp_on));
		st_next.pslverr = 1'b0;
		st_next.prdata  = 32'h00000000;
		if (apb_acc && !st_reg.pready) begin
			unique case (paddr)
				OFS_DATA, OFS_CTRL: st_next.prdata = 32'h00000000;
				OFS_STAT: begin
					st_next.prdata[STAT_TALK] = st_reg.talk;
					st_next.prdata[STAT_TONE] = (st_reg.ps == P_TONE);
					st_next.prdata[STAT_QUIT] = st_reg.quit_pend;
					st_next.prdata[STAT_TXB]  = st_reg.tx_on;
					st_next.prdata[STAT_DICT] = st_reg.dict_loaded;
					st_next.prdata[STAT_RPL]  = st_reg.rp_on;
					st_next.prdata[STAT_MODE +: 2] = st_reg.mode;
				end
				OFS_PROTO: st_next.prdata = {24'h000000, st_reg.proto};
				OFS_AUDIO: st_next.prdata = {24'h000000, st_reg.aud_ctrl};
				default:   st_next.pslverr = 1'b1;  // unmapped
			endcase
		end
		if (apb_done && pwrite) begin
			if (paddr == OFS_PROTO)
				st_next.proto = pwdata[7:0];
			if (paddr == OFS_AUDIO)
				st_next.aud_ctrl = pwdata[7:0];
			if (paddr == OFS_CTRL && pwdata[CTRL_DEND] &&
			    st_reg.ps == P_DICT) begin
				st_next.ps          = P_TEXT;
				st_next.dict_loaded = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg       <= '0;
			st_reg.ps    <= P_TEXT;
			st_reg.mode  <= MODE_TEXT;
			st_reg.proto <= PROTO_RST;
			st_reg.aud_ctrl <= AUDIO_RST;
			st_reg.tempo <= 16'h0001;
			st_reg.txd   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// frame buffer, no reset needed
	always_ff @(posedge clk) begin
		if (buf_we)
			fbuf[st_reg.wptr[AW-1:0]] <= buf_wd;
	end

	assign prdata            = st_reg.prdata;
	assign pready            = st_reg.pready;
	assign pslverr           = st_reg.pslverr;
	assign serial_tx_pin     = st_reg.txd;
	assign talk_status       = st_reg.talk;
	assign analog_out_pins   = st_reg.aout;
	assign digital_audio_pin = st_reg.nv_dict & 1'b0;
	assign nv_we             = st_reg.nv_we;
	assign nv_dict_sel       = st_reg.nv_dict;
	assign nv_addr           = st_reg.nv_addr;
	assign nv_wdata          = st_reg.nv_wdata;
	assign nv_erase_dict     = st_reg.nv_erase;
	assign nv_commit         = st_reg.nv_commit;
	assign nv_raddr          = st_reg.rp_addr;

	// checks
	sequence tone_byte4_s;
		src_v && st_reg.ps == P_TONE && st_reg.pos == 2'h3;
	endsequence
	sequence play_frame_s;
		tone_byte4_s and (buf_wd == 32'h00000101);
	endsequence
	proto_reset_a: assert property (@(posedge clk)
		$rose(rst_n) |-> prdata == 32'h0 && st_reg.proto == PROTO_RST)
		else $error("protocol options not 128 after reset");
	aud_reset_a: assert property (@(posedge clk)
		$rose(rst_n) |-> st_reg.aud_ctrl == AUDIO_RST)
		else $error("audio control not 0 after reset");
	greet_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
		src_v && st_reg.ps == P_CMD && src_b == CH_W && st_reg.nd &&
		st_reg.num == NUM_GREET && !st_reg.rp_on
		|=> nv_erase_dict && st_reg.ps == P_GREET)
		else $error("greeting store did not erase dictionary");
	greet_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
		src_v && st_reg.ps == P_GREET && src_b == 8'h00
		|=> nv_commit && !nv_we ##1 !nv_commit)
		else $error("zero byte did not commit greeting");
	frame_pos_a: assert property (@(posedge clk) disable iff (!rst_n)
		tone_byte4_s |=> st_reg.pos == 2'h0)
		else $error("frame position not restarted");
	chip_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.tx_on && !st_next.tx_on
		|-> st_reg.tx_idx == (st_reg.tx_set ? 5'd23 : 5'd8))
		else $error("reply byte count wrong");
	play_talk_a: assert property (@(posedge clk) disable iff (!rst_n)
		play_frame_s |=> talk_status && st_reg.playing)
		else $error("talk status not raised on play");
	autoplay_a: assert property (@(posedge clk) disable iff (!rst_n)
		full |=> st_reg.playing)
		else $error("full buffer did not start play");
	hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!st_reg.playing |=> $stable(st_reg.rptr))
		else $error("frames consumed before play");
	quit_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.quit_pend && apb_acc && pwrite && paddr == OFS_DATA
		|=> !pready)
		else $error("data accepted while draining after quit");
	no_digital_a: assert property (@(posedge clk) disable iff (!rst_n)
		!digital_audio_pin)
		else $error("tone output on digital audio pin");
endmodule // synth_cmd_tone

// [pkg/synth_cmd_pkg.sv]
package synth_cmd_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_DATA  = 8'h00;
	localparam logic [7:0] OFS_STAT  = 8'h04;
	localparam logic [7:0] OFS_CTRL  = 8'h08;
	localparam logic [7:0] OFS_PROTO = 8'h0c;
	localparam logic [7:0] OFS_AUDIO = 8'h10;
	// reset values
	localparam logic [7:0] PROTO_RST = 8'h80;
	localparam logic [7:0] AUDIO_RST = 8'h00;
	// status and control bit positions
	localparam int STAT_TALK = 0;
	localparam int STAT_TONE = 1;
	localparam int STAT_QUIT = 2;
	localparam int STAT_TXB  = 3;
	localparam int STAT_DICT = 4;
	localparam int STAT_RPL  = 5;
	localparam int STAT_MODE = 6;
	localparam int CTRL_DEND = 0;
	// sizes
	localparam int GREET_MAX   = 234;
	localparam int DICT_MAX    = 16384;
	localparam int BUF_BYTES   = 2048;
	localparam int FRAME_BYTES = 4;
	localparam int CHIP_BYTES  = 8;
	localparam int SET_BYTES   = 23;
	// command characters and argument numbers
	localparam logic [7:0] CH_CTRLA = 8'h01;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_L = 8'h4c;
	localparam logic [7:0] CH_Q = 8'h3f;
	localparam logic [7:0] CH_J = 8'h4a;
	localparam logic [7:0] CH_G = 8'h47;
	localparam logic [7:0] CH_N = 8'h4e;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_D = 8'h44;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] NUM_GREET = 8'hff;
	localparam logic [7:0] NUM_CHIP  = 8'h06;
	localparam logic [7:0] NUM_SET   = 8'h0c;
	// synthesis modes
	localparam logic [1:0] MODE_CHAR = 2'h0;
	localparam logic [1:0] MODE_PHON = 2'h1;
	localparam logic [1:0] MODE_TEXT = 2'h2;
	// settings reply defaults, in send order
	localparam logic [7:0] SET_DFLT [0:SET_BYTES-1] = '{
		8'h02, 8'h06, 8'h05, 8'h32, 8'h01, 8'h05, 8'h01, 8'h05,
		8'h00, 8'h00, 8'h08, 8'h05, 8'h00, 8'h01, 8'h80, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// parser states
	typedef enum logic [2:0] {P_TEXT, P_CMD, P_GREET, P_DICT, P_TONE} parse_t;
endpackage

// [tb/nv_store_model.sv]
`timescale 1ns/100ps
// nonvolatile store beside the block; no reset, contents survive it
module nv_store_model (
	input  wire logic        clk,
	input  wire logic        nv_we,
	input  wire logic        nv_dict_sel,
	input  wire logic [13:0] nv_addr,
	input  wire logic [7:0]  nv_wdata,
	input  wire logic        nv_erase_dict,
	input  wire logic        nv_commit,
	input  wire logic [7:0]  nv_raddr,
	output logic      [7:0]  nv_rdata,
	output logic      [7:0]  nv_greet_len
);
	logic [7:0] mem [0:255];      // greeting cells
	int         erase_cnt = 0;    // erase pulses seen
	int         dict_cnt  = 0;    // dictionary bytes since erase
	logic       rd_seen   = 1'b0; // replay got past first byte
	// erased flash reads all ones
	initial begin
		foreach (mem[i])
			mem[i] = 8'hff;
		nv_greet_len = 8'h00;
		nv_rdata = 8'h00;
	end
	// writes as the block commands them, read one cycle late
	always @(posedge clk) begin
		if (nv_erase_dict) begin
			erase_cnt <= erase_cnt + 1;
			dict_cnt  <= 0;
		end else if (nv_we && nv_dict_sel)
			dict_cnt <= dict_cnt + 1;
		if (nv_we && !nv_dict_sel)
			mem[nv_addr[7:0]] <= nv_wdata;
		if (nv_commit)
			nv_greet_len <= nv_addr[7:0];
		nv_rdata <= mem[nv_raddr];
		if (nv_raddr == 8'h01)
			rd_seen <= 1'b1;
	end
endmodule // nv_store_model

// [tb/test_synth_cmd_tone.sv]
`timescale 1ns/100ps
module test_synth_cmd_tone
	import synth_cmd_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, serial_tx_pin, talk_status, err;
	logic        digital_audio_pin, nv_we, nv_dict_sel;
	logic        nv_erase_dict, nv_commit;
	logic [7:0]  analog_out_pins, nv_wdata, nv_raddr, nv_rdata;
	logic [7:0]  nv_greet_len;
	logic [13:0] nv_addr;
	logic [7:0]  rx_b [0:SET_BYTES-1]; // bytes caught on the tx pin
	logic        heard = 1'b0;  // tone output seen on analog pins
	logic        da_bad = 1'b0; // digital pin ever left low
	int          n_fail = 0, n_tests = 0;

	always #2 clk = ~clk;

	// short divisors and a four-frame buffer keep the run small
	synth_cmd_tone #(.BAUD_DIV(4), .TICK_DIV(4), .BUF_FR(4),
		.REV_MAJOR(8'h03), .REV_MINOR(8'h27)) DUT (
		.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .serial_tx_pin, .talk_status,
		.analog_out_pins, .digital_audio_pin, .nv_we, .nv_dict_sel,
		.nv_addr, .nv_wdata, .nv_erase_dict, .nv_commit, .nv_raddr,
		.nv_rdata, .nv_greet_len);
	nv_store_model nv (.clk, .nv_we, .nv_dict_sel, .nv_addr, .nv_wdata,
		.nv_erase_dict, .nv_commit, .nv_raddr, .nv_rdata, .nv_greet_len);

	// audio pin watch, away from the launching edge
	always @(negedge clk) begin
		if (analog_out_pins !== 8'h00)
			heard = 1'b1;
		if (rst_n && digital_audio_pin !== 1'b0)
			da_bad = 1'b1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// a bounded wait ran out
	task automatic stall();
		chk(32'h0, 32'h1);
		complete_run();
	endtask

	// one apb transfer; held until pready is seen at an edge
	task automatic apb(input logic [7:0] a, input logic w,
			input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 4000)
			stall();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic sendb(input logic [7:0] b);
		apb(OFS_DATA, 1'b1, {24'h0, b});
	endtask

	// escape byte, then the command text
	task automatic cmd(input string s);
		sendb(CH_CTRLA);
		foreach (s[i])
			sendb(s[i]);
	endtask

	// tone frame, first byte in the top lane
	task automatic frame(input logic [31:0] f);
		for (int k = 3; k >= 0; k--)
			sendb(f[8*k+:8]);
	endtask

	// 8n1 receiver, sampling mid-bit on falling edges
	task automatic rx(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			for (t = 0; t < 3000 && serial_tx_pin !== 1'b0; t++)
				@(negedge clk);
			if (t == 3000)
				stall();
			repeat (2) @(negedge clk);
			for (int k = 0; k < 8; k++) begin
				repeat (4) @(negedge clk);
				rx_b[i][k] = serial_tx_pin;
			end
			repeat (4) @(negedge clk);
			chk(32'(serial_tx_pin), 32'h1);
		end
	endtask

	// no further start bit after a reply
	task automatic quiet();
		int t = 0;
		repeat (60) begin
			@(negedge clk);
			if (serial_tx_pin !== 1'b1)
				t++;
		end
		chk(32'(t), 32'h0);
	endtask

	initial begin
		int t;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(OFS_PROTO, 1'b0, 32'h0);
		chk(rd, 32'h80);
		apb(OFS_AUDIO, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(OFS_PROTO, 1'b1, 32'hff);
		apb(OFS_AUDIO, 1'b1, 32'h5a);
		apb(OFS_PROTO, 1'b0, 32'h0);
		chk(rd, 32'hff);
		apb(OFS_AUDIO, 1'b0, 32'h0);
		chk(rd, 32'h5a);
		apb(8'h14, 1'b0, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("test registers done");
		cmd("255Whi");
		sendb(8'h00);
		repeat (4) @(posedge clk);
		chk(32'(nv.erase_cnt), 32'h1);
		chk(32'(nv.nv_greet_len), 32'h2);
		chk({16'h0, nv.mem[0], nv.mem[1]}, 32'h6869);
		chk(32'(nv.rd_seen), 32'h0);
		$display("test greeting done");
		cmd("L");
		frame(32'h11223344);
		apb(OFS_CTRL, 1'b1, 32'h1);
		chk(32'(nv.erase_cnt), 32'h2);
		chk(32'(nv.dict_cnt), 32'h4);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk(32'(rd[STAT_DICT]), 32'h1);
		$display("test dictionary done");
		cmd("6?");
		rx(8);
		chk(32'({rx_b[6], rx_b[7]}), 32'h2703);
		quiet();
		cmd("C");
		apb(OFS_STAT, 1'b0, 32'h0);
		chk(32'(rd[STAT_MODE+:2]), 32'(MODE_CHAR));
		cmd("D");
		cmd("12?");
		rx(SET_BYTES);
		quiet();
		chk(32'(rx_b[0]), 32'(MODE_PHON));
		chk(32'(rx_b[8]), 32'h1);
		chk(32'(rx_b[10]), 32'(BUF_BYTES / 256));
		chk(32'({rx_b[14], rx_b[15]}), 32'hff5a);
		cmd("T");
		cmd("100G");
		cmd("3N");
		apb(OFS_PROTO, 1'b0, 32'h0);
		chk(rd, 32'h64);
		apb(OFS_AUDIO, 1'b0, 32'h0);
		chk(rd, 32'h3);
		$display("test queries done");
		cmd("J");
		frame(32'h00ff0100);
		frame(32'h0a020000);
		frame(32'h0a000300);
		repeat (20) @(negedge clk);
		chk(32'(talk_status), 32'h0);
		frame(32'h00000101);
		@(negedge clk);
		chk(32'(talk_status), 32'h1);
		frame(32'h0);
		for (t = 0; t < 2000 && talk_status !== 1'b0; t++)
			@(negedge clk);
		chk(32'(t < 2000), 32'h1);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk(32'({rd[STAT_MODE+:2], rd[STAT_TONE]}), 32'h4);
		chk(32'({heard, da_bad}), 32'h2);
		$display("test tone done");
		// four frames fill the buffer, so play starts unasked
		cmd("J");
		frame(32'h00800100);
		repeat (3) frame(32'h0a010000);
		repeat (3) @(negedge clk);
		chk(32'(talk_status), 32'h1);
		frame(32'h0);
		// a data byte after quit waits until the buffer is played
		sendb(8'h20);
		chk(32'(talk_status), 32'h0);
		$display("test overflow done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (50) @(posedge clk);
		chk(32'(nv.rd_seen), 32'h1);
		apb(OFS_PROTO, 1'b0, 32'h0);
		chk(rd, 32'h80);
		$display("test replay done");
		complete_run();
	end
endmodule // test_synth_cmd_tone
